// file: hw/ssr_pkg.sv
//----------------------------------------------------------------------
// Functional notes
//----------------------------------------------------------------------
// Functional notes
// [RL1] Data buffer writes go to transmit store; reads return only received data.
// [RL2] Mode field: 00 port, outputs off; 01 serial; 10 two-wire; 11 reserved.
// [RL3] Soft reset starts on reset bits written 10, then 01 in next write.
// [RL4] Reset monitor reads 0 during soft reset, 1 otherwise and after chip reset.
// [RL5] Transfer flag reads 1 while a transfer runs, 0 once it ended.
// [RL6] Shift flag reads 1 while a byte is shifting, 0 otherwise.
// [RL7] Status B bits 7 to 4, 1 and 0 read as ones.
// [RL8] Control B is write-only; software never read-modify-writes it.
// [RL9] Control A is write-only; software writes it as a whole byte.
// [RL10] Software writes control B with bits 7 to 5 zero and bit 4 one.
// [RL11] Software enters port mode only after a transfer has completed.
// [RL12] Software checks the line is high before serial or two-wire mode.
// [RL13] Clock select sits in control A bits 2 to 0.
// [RL14] Codes 0 to 6 halve from clock/16, prescale halves more; 7 external.
// [RL15] Start bit 1 runs, 0 stops; abort halts at once and self-clears.
// [RL16] Data shifts out and in least significant bit first on serial clock.
// [RL17] Internal clock waits with clock stopped until the buffer is serviced.
// [RL18] Finished soft reset returns logic and flags to initial; monitor back to 1. Code keeps control, mode, prescale and interrupt registers.
`default_nettype none
package ssr_pkg;
    localparam int unsigned IDX_LSB        = 2;
    localparam logic [7:0]  IDX_STATUS_A   = 8'h20;
    localparam logic [7:0]  IDX_CONTROL_A  = 8'h20;
    localparam logic [7:0]  IDX_DATA_BUF   = 8'h21;
    localparam logic [7:0]  IDX_CONTROL_B  = 8'h23;
    localparam logic [7:0]  IDX_STATUS_B   = 8'h23;
    localparam logic [7:0]  IDX_IRQ_STATUS = 8'h24;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'h25;
    localparam logic [7:0]  IDX_OPTIONS    = 8'h26;
    localparam int unsigned CA_START       = 7;
    localparam int unsigned CA_ABORT       = 6;
    localparam int unsigned CA_DIR_LSB     = 4;
    localparam int unsigned CA_CLK_LSB     = 0;
    localparam int unsigned CB_MODE_LSB    = 2;
    localparam int unsigned CB_RST_LSB     = 0;
    localparam int unsigned SB_ACTIVE      = 3;
    localparam int unsigned SB_SHIFT       = 2;
    localparam logic [7:0]  SB_ONES        = 8'hF3;
    localparam logic [7:0]  CTRL_A_RESET   = 8'h00;
    localparam logic [1:0]  MODE_PORT      = 2'h0;
    localparam logic [1:0]  MODE_SIO       = 2'h1;
    localparam logic [1:0]  MODE_BUS       = 2'h2;
    localparam logic [1:0]  RST_FIRST      = 2'h2;
    localparam logic [1:0]  RST_SECOND     = 2'h1;
    localparam logic [1:0]  DIR_TX         = 2'h0;
    localparam logic [1:0]  DIR_RX         = 2'h1;
    localparam logic [1:0]  DIR_TXRX       = 2'h2;
    localparam logic [2:0]  CLK_EXT        = 3'h7;
    localparam logic [10:0] HALF_BASE      = 11'h008;
    localparam logic [1:0]  SRST_CYCLES    = 2'h2;
    localparam int unsigned IRQ_W          = 3;
    localparam int unsigned IRQ_TX_EMPTY   = 0;
    localparam int unsigned IRQ_RX_FULL    = 1;
    localparam int unsigned IRQ_DONE       = 2;
    typedef enum logic [1:0] {SSR_IDLE, SSR_LOAD, SSR_SHIFT} ssr_state_e;
endpackage
`default_nettype wire

// file: hw/ssr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssr_if;
    logic [1:0] mode;
    logic       start;
    logic       abort;
    logic [1:0] dir;
    logic [2:0] clk_sel;
    logic       prescale;
    logic       soft_rst;
    logic [7:0] tx_data;
    logic       tx_wr;
    logic       rx_rd;
    logic       active;
    logic       shifting;
    logic [7:0] rx_data;
    logic       ev_tx_empty;
    logic       ev_rx_full;
    logic       ev_done;
    modport ctrl (output mode, start, abort, dir, clk_sel, prescale, soft_rst, tx_data,
                  tx_wr, rx_rd, input active, shifting, rx_data, ev_tx_empty, ev_rx_full,
                  ev_done);
    modport eng (input mode, start, abort, dir, clk_sel, prescale, soft_rst, tx_data,
                 tx_wr, rx_rd, output active, shifting, rx_data, ev_tx_empty, ev_rx_full,
                 ev_done);
endinterface
`default_nettype wire

// file: hw/ssr_engine.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_engine (
    input  wire logic hclk,
    input  wire logic hresetn,
    ssr_if.eng        bus,
    input  wire logic sck_n_in,
    input  wire logic si_in,
    output logic      sck_n_out,
    output logic      sck_n_oe,
    output logic      so_out,
    output logic      so_oe
);
    typedef struct packed {
        ssr_pkg::ssr_state_e st;
        logic [10:0]         div;
        logic                sck_n;
        logic                sck_oe;
        logic                so;
        logic                so_oe;
        logic [2:0]          bitc;
        logic [7:0]          shreg;
        logic [7:0]          tx_buf;
        logic                tx_full;
        logic [7:0]          rx_buf;
        logic                rx_full;
        logic                active;
        logic                shifting;
        logic                ev_tx;
        logic                ev_rx;
        logic                ev_done;
        logic                sck_d;
    } ssr_eng_s;

    ssr_eng_s s;
    ssr_eng_s nxt_s;
    logic     ext;
    logic     tick;
    logic     lead;
    logic     trail;
    logic     need_tx;
    logic     need_rx;
    logic     ready;

    function automatic logic [10:0] half_period(input logic [2:0] sel, input logic presc);
        half_period = (ssr_pkg::HALF_BASE << sel) << presc; // [RL14]
    endfunction

    always_comb begin
        ext     = bus.clk_sel == ssr_pkg::CLK_EXT; // [RL13]
        tick    = !ext && (s.div == half_period(bus.clk_sel, bus.prescale) - 11'h001);
        lead    = ext ? (s.sck_d & ~sck_n_in) : (tick & s.sck_n);
        trail   = ext ? (~s.sck_d & sck_n_in) : (tick & ~s.sck_n);
        need_tx = bus.dir != ssr_pkg::DIR_RX;
        need_rx = bus.dir != ssr_pkg::DIR_TX;
        ready   = (!need_tx || s.tx_full) && (!need_rx || !s.rx_full);
        nxt_s         = s;
        nxt_s.ev_tx   = 1'b0;
        nxt_s.ev_rx   = 1'b0;
        nxt_s.ev_done = 1'b0;
        nxt_s.sck_d   = sck_n_in;
        nxt_s.sck_oe  = (bus.mode == ssr_pkg::MODE_SIO) && !ext;
        nxt_s.so_oe   = bus.mode != ssr_pkg::MODE_PORT; // [RL2]
        if (bus.soft_rst || bus.mode != ssr_pkg::MODE_SIO) begin // [RL18]
            nxt_s.st       = ssr_pkg::SSR_IDLE;
            nxt_s.active   = 1'b0;
            nxt_s.shifting = 1'b0;
            nxt_s.sck_n    = 1'b1;
            nxt_s.div      = '0;
            nxt_s.bitc     = '0;
            nxt_s.shreg    = '0;
            nxt_s.tx_full  = 1'b0;
            nxt_s.rx_full  = 1'b0;
        end else if (bus.abort) begin // [RL15]
            nxt_s.st       = ssr_pkg::SSR_IDLE;
            nxt_s.active   = 1'b0;
            nxt_s.shifting = 1'b0;
            nxt_s.sck_n    = 1'b1;
            nxt_s.div      = '0;
            nxt_s.bitc     = '0;
            nxt_s.ev_done  = s.active;
        end else begin
            case (s.st)
                ssr_pkg::SSR_IDLE: begin
                    if (bus.start) begin // [RL15]
                        nxt_s.active = 1'b1; // [RL5]
                        nxt_s.so     = 1'b1;
                        nxt_s.st     = ssr_pkg::SSR_LOAD;
                    end
                end
                ssr_pkg::SSR_LOAD: begin
                    if (!bus.start) begin
                        nxt_s.active  = 1'b0; // [RL5]
                        nxt_s.ev_done = 1'b1;
                        nxt_s.st      = ssr_pkg::SSR_IDLE;
                    end else if (ready) begin
                        nxt_s.shreg    = need_tx ? s.tx_buf : 8'h00;
                        nxt_s.tx_full  = need_tx ? 1'b0 : s.tx_full;
                        nxt_s.ev_tx    = need_tx;
                        nxt_s.shifting = 1'b1; // [RL6]
                        nxt_s.bitc     = '0;
                        nxt_s.div      = '0;
                        nxt_s.st       = ssr_pkg::SSR_SHIFT;
                    end
                    // Clock held high here while the buffer is not serviced [RL17]
                end
                ssr_pkg::SSR_SHIFT: begin
                    if (!ext) begin
                        nxt_s.div = tick ? 11'h000 : s.div + 11'h001;
                        if (tick) begin
                            nxt_s.sck_n = ~s.sck_n;
                        end
                    end
                    if (lead) begin
                        nxt_s.so = s.shreg[0]; // [RL16]
                    end
                    if (trail) begin
                        nxt_s.shreg = {si_in, s.shreg[7:1]}; // [RL16]
                        nxt_s.bitc  = s.bitc + 3'h1;
                        if (s.bitc == 3'h7) begin
                            nxt_s.shifting = 1'b0; // [RL6]
                            nxt_s.st       = ssr_pkg::SSR_LOAD;
                            if (need_rx) begin
                                nxt_s.rx_buf  = {si_in, s.shreg[7:1]};
                                nxt_s.rx_full = 1'b1;
                                nxt_s.ev_rx   = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    nxt_s.st = ssr_pkg::SSR_IDLE;
                end
            endcase
        end
        // Host accesses last, so a buffer write beats a same-cycle load
        if (bus.tx_wr) begin
            nxt_s.tx_buf  = bus.tx_data;
            nxt_s.tx_full = 1'b1;
        end
        if (bus.rx_rd && !nxt_s.ev_rx) begin
            nxt_s.rx_full = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s       <= '0;
            s.st    <= ssr_pkg::SSR_IDLE;
            s.sck_n <= 1'b1;
            s.sck_d <= 1'b1;
            s.so    <= 1'b1;
        end else begin
            s <= nxt_s;
        end
    end

    assign bus.active      = s.active;
    assign bus.shifting    = s.shifting;
    assign bus.rx_data     = s.rx_buf;
    assign bus.ev_tx_empty = s.ev_tx;
    assign bus.ev_rx_full  = s.ev_rx;
    assign bus.ev_done     = s.ev_done;
    assign sck_n_out       = s.sck_n;
    assign sck_n_oe        = s.sck_oe;
    assign so_out          = s.so;
    assign so_oe           = s.so_oe;

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_lsb_first;
        (s.st == ssr_pkg::SSR_SHIFT) && lead && !bus.abort && !bus.soft_rst
            && bus.mode == ssr_pkg::MODE_SIO |=> so_out == $past(s.shreg[0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("so not lsb"); // [RL16]
    property p_wait_clk;
        (s.st == ssr_pkg::SSR_LOAD) && !ready |-> sck_n_out;
    endproperty
    a_wait_clk: assert property (p_wait_clk) else $error("clock runs in wait"); // [RL17]
    property p_srst;
        bus.soft_rst |=> (s.st == ssr_pkg::SSR_IDLE) && !s.active && !s.shifting;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset not applied"); // [RL18]
    property p_shift_flag;
        s.shifting |-> s.active && s.st == ssr_pkg::SSR_SHIFT;
    endproperty
    a_shift_flag: assert property (p_shift_flag) else $error("shift flag wrong"); // [RL6]
    c_rx_byte: cover property (s.ev_rx);
    c_tx_empty: cover property (s.ev_tx);
endmodule
`default_nettype wire

// file: hw/ssr_top.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        sck_n_in,
    input  wire logic        si_in,
    output logic             sck_n_out,
    output logic             sck_n_oe,
    output logic             so_out,
    output logic             so_oe,
    output logic             irq
);
    typedef struct packed {
        logic                        wpend;
        logic [7:0]                  widx;
        logic [31:0]                 rdata;
        logic                        rdy;
        logic [7:0]                  ctrl_a;
        logic [1:0]                  mode;
        logic [1:0]                  rst_prev;
        logic [1:0]                  srst_cnt;
        logic [ssr_pkg::IRQ_W-1:0]   istat;
        logic [ssr_pkg::IRQ_W-1:0]   imask;
        logic                        presc;
        logic                        abort;
        logic                        tx_wr;
        logic                        rx_rd;
        logic [7:0]                  tx_data;
        logic                        irq;
    } ssr_top_s;

    ssr_top_s s;
    ssr_top_s nxt_s;
    logic     take;
    logic [7:0] aidx;
    logic [ssr_pkg::IRQ_W-1:0] ev;

    ssr_if ifc ();

    ssr_engine u_engine (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .bus       (ifc.eng),
        .sck_n_in  (sck_n_in),
        .si_in     (si_in),
        .sck_n_out (sck_n_out),
        .sck_n_oe  (sck_n_oe),
        .so_out    (so_out),
        .so_oe     (so_oe)
    );

    //------------------------------------------------------------------
    // Bus slave, registers and interrupt status
    //------------------------------------------------------------------
    always_comb begin
        take = hsel && hready && htrans[1];
        aidx = haddr[ssr_pkg::IDX_LSB +: 8];
        ev   = '0;
        ev[ssr_pkg::IRQ_TX_EMPTY] = ifc.ev_tx_empty;
        ev[ssr_pkg::IRQ_RX_FULL]  = ifc.ev_rx_full;
        ev[ssr_pkg::IRQ_DONE]     = ifc.ev_done;
        nxt_s       = s;
        nxt_s.rdy   = 1'b1;
        nxt_s.abort = 1'b0;
        nxt_s.tx_wr = 1'b0;
        nxt_s.rx_rd = 1'b0;
        nxt_s.wpend = take && hwrite;
        nxt_s.widx  = aidx;
        if (s.srst_cnt != 2'h0) begin
            nxt_s.srst_cnt = s.srst_cnt - 2'h1;
        end
        // Data phase of a write: the value stands on hwdata now
        if (s.wpend) begin
            case (s.widx)
                ssr_pkg::IDX_CONTROL_A: begin
                    nxt_s.ctrl_a = hwdata[7:0]; // [RL13]
                    nxt_s.ctrl_a[ssr_pkg::CA_ABORT] = 1'b0; // [RL15]
                    nxt_s.abort = hwdata[ssr_pkg::CA_ABORT];
                    if (hwdata[ssr_pkg::CA_ABORT]) begin
                        nxt_s.ctrl_a[ssr_pkg::CA_START] = 1'b0; // [RL15]
                    end
                end
                ssr_pkg::IDX_DATA_BUF: begin
                    nxt_s.tx_data = hwdata[7:0]; // [RL1]
                    nxt_s.tx_wr   = 1'b1;
                end
                ssr_pkg::IDX_CONTROL_B: begin
                    nxt_s.mode     = hwdata[ssr_pkg::CB_MODE_LSB +: 2]; // [RL2]
                    nxt_s.rst_prev = hwdata[ssr_pkg::CB_RST_LSB +: 2];
                    if (s.rst_prev == ssr_pkg::RST_FIRST
                        && hwdata[ssr_pkg::CB_RST_LSB +: 2] == ssr_pkg::RST_SECOND) begin
                        nxt_s.srst_cnt = ssr_pkg::SRST_CYCLES; // [RL3]
                        nxt_s.rst_prev = 2'h0;
                    end
                end
                ssr_pkg::IDX_IRQ_MASK: begin
                    nxt_s.imask = hwdata[ssr_pkg::IRQ_W-1:0];
                end
                ssr_pkg::IDX_OPTIONS: begin
                    nxt_s.presc = hwdata[0]; // [RL14]
                end
                default: begin
                    nxt_s.presc = s.presc;
                end
            endcase
        end
        // Read data is latched at the address edge; side effects happen there
        if (take && !hwrite) begin
            case (aidx)
                ssr_pkg::IDX_STATUS_A: begin
                    nxt_s.rdata = {31'h00000000, s.srst_cnt == 2'h0}; // [RL4]
                end
                ssr_pkg::IDX_DATA_BUF: begin
                    nxt_s.rdata = {24'h000000, ifc.rx_data}; // [RL1]
                    nxt_s.rx_rd = 1'b1;
                end
                ssr_pkg::IDX_STATUS_B: begin
                    nxt_s.rdata = {24'h000000, ssr_pkg::SB_ONES}; // [RL7]
                    nxt_s.rdata[ssr_pkg::SB_ACTIVE] = ifc.active; // [RL5]
                    nxt_s.rdata[ssr_pkg::SB_SHIFT]  = ifc.shifting; // [RL6]
                end
                ssr_pkg::IDX_IRQ_STATUS: begin
                    nxt_s.rdata = {29'h00000000, s.istat};
                    nxt_s.istat = '0;
                end
                ssr_pkg::IDX_IRQ_MASK: begin
                    nxt_s.rdata = {29'h00000000, s.imask};
                end
                ssr_pkg::IDX_OPTIONS: begin
                    nxt_s.rdata = {31'h00000000, s.presc};
                end
                default: begin
                    nxt_s.rdata = 32'h00000000;
                end
            endcase
        end
        // A new event beats a clear-on-read in the same cycle
        nxt_s.istat = nxt_s.istat | ev;
        nxt_s.irq   = |(nxt_s.istat & nxt_s.imask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s        <= '0;
            s.rdy    <= 1'b1;
            s.ctrl_a <= ssr_pkg::CTRL_A_RESET;
            s.mode   <= ssr_pkg::MODE_PORT;
        end else begin
            s <= nxt_s;
        end
    end

    assign hrdata       = s.rdata;
    assign hreadyout    = s.rdy;
    assign hresp        = 1'b0;
    assign irq          = s.irq;
    assign ifc.mode     = s.mode;
    assign ifc.start    = s.ctrl_a[ssr_pkg::CA_START];
    assign ifc.abort    = s.abort;
    assign ifc.dir      = s.ctrl_a[ssr_pkg::CA_DIR_LSB +: 2];
    assign ifc.clk_sel  = s.ctrl_a[ssr_pkg::CA_CLK_LSB +: 3];
    assign ifc.prescale = s.presc;
    assign ifc.soft_rst = s.srst_cnt != 2'h0;
    assign ifc.tx_data  = s.tx_data;
    assign ifc.tx_wr    = s.tx_wr;
    assign ifc.rx_rd    = s.rx_rd;

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_rd_buf;
        take && !hwrite && aidx == ssr_pkg::IDX_DATA_BUF
            |=> hrdata[7:0] == $past(ifc.rx_data);
    endproperty
    a_rd_buf: assert property (p_rd_buf) else $error("buffer read not rx data"); // [RL1]
    property p_mode;
        s.wpend && s.widx == ssr_pkg::IDX_CONTROL_B
            |=> ifc.mode == $past(hwdata[ssr_pkg::CB_MODE_LSB +: 2]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not taken"); // [RL2]
    property p_srst_seq;
        s.wpend && s.widx == ssr_pkg::IDX_CONTROL_B && s.rst_prev == ssr_pkg::RST_FIRST
            && hwdata[1:0] == ssr_pkg::RST_SECOND |=> ifc.soft_rst [*2] ##1 !ifc.soft_rst;
    endproperty
    a_srst_seq: assert property (p_srst_seq) else $error("soft reset sequence"); // [RL3]
    property p_mon;
        take && !hwrite && aidx == ssr_pkg::IDX_STATUS_A |=> hrdata[0] == !$past(ifc.soft_rst);
    endproperty
    a_mon: assert property (p_mon) else $error("monitor bit wrong"); // [RL4]
    property p_statb;
        take && !hwrite && aidx == ssr_pkg::IDX_STATUS_B
            |=> hrdata[7:4] == 4'hF && hrdata[1:0] == 2'h3
                && hrdata[ssr_pkg::SB_ACTIVE] == $past(ifc.active);
    endproperty
    a_statb: assert property (p_statb) else $error("status b wrong"); // [RL7]
    property p_abort_pulse;
        ifc.abort |=> !ifc.abort && !ifc.start;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("abort stuck"); // [RL15]
    property p_clk_sel;
        s.wpend && s.widx == ssr_pkg::IDX_CONTROL_A |=> ifc.clk_sel == $past(hwdata[2:0]);
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock select lost"); // [RL13]
    property p_irq;
        irq == |(s.istat & s.imask);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
    c_soft_reset: cover property (ifc.soft_rst);
    c_abort: cover property (ifc.abort && ifc.active);
    c_irq: cover property (irq);
endmodule
`default_nettype wire

// file: dv/ssr_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_peer_model (
    input  wire logic       rst_n,
    input  wire logic       sck_n,
    input  wire logic       so,
    input  wire logic [7:0] tx_byte,
    output logic            si,
    output logic      [7:0] rx_byte
);
    logic [2:0] bits;
    // --------------------------------------------------------------
    // Shift: drive at the falling clock, capture at the rising one
    // --------------------------------------------------------------
    always @(sck_n or negedge rst_n) begin
        if (!rst_n) begin
            si      <= 1'b1;
            bits    <= 3'h0;
            rx_byte <= 8'h00;
        end else if (sck_n === 1'b0) begin
            si <= tx_byte[bits];
        end else if (sck_n === 1'b1) begin
            rx_byte <= {so, rx_byte[7:1]};
            bits    <= bits + 3'h1;
            // Line inverted after the last bit: show a stale-looking value
            if (bits == 3'h7) begin
                si <= ~si;
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/sync_serial_sio_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sync_serial_sio_regs_bench;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, sck_n_out, sck_n_oe, so_out, so_oe, irq, si;
    logic [7:0]  ptx = 8'h00, prx, dat;
    logic [16:0] seed = 17'h177F1;
    int          fail_count = 0, compares = 0, cyc = 0, k;
    // Idle serial lines float high through pull-ups
    wire sck_pin = sck_n_oe ? sck_n_out : 1'b1;
    wire so_pin  = so_oe ? so_out : 1'b1;
    always #5 hclk = ~hclk;
    ssr_top ssr_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sck_n_in(sck_pin),
        .si_in(si), .sck_n_out(sck_n_out), .sck_n_oe(sck_n_oe), .so_out(so_out),
        .so_oe(so_oe), .irq(irq));
    ssr_peer_model ssr_peer_model_i (.rst_n(hresetn), .sck_n(sck_pin), .so(so_pin),
        .tx_byte(ptx), .si(si), .rx_byte(prx));
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // --------------------------------------------------------------
    // Single-word AHB-Lite transfer, waits on hready in both phases
    // --------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {22'h0, idx, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, exp);
        chk(hresp, 1'b0);
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(8'h20, 32'h01);
        rchk(8'h23, 32'hF3);
        rchk(8'h30, 32'h00);
        // Control B written whole, bits 7:5 zero and bit 4 one; modes port, two-wire, serial
        for (k = 0; k < 3; k++) begin
            while (sck_pin !== 1'b1 || si !== 1'b1) @(posedge hclk);
            bus(1'b1, 8'h23, 8'h10 | 8'(((k * 2) % 3) << 2));
            // Mode lands at the data edge, the pin enables one edge later
            repeat (2) @(posedge hclk);
            chk(so_oe, k != 0);
            chk(sck_n_oe, k == 2);
        end
        bus(1'b1, 8'h20, 8'h07);
        repeat (2) @(posedge hclk);
        chk(sck_n_oe, 1'b0);
        bus(1'b1, 8'h25, 8'h02);
        for (k = 0; k < 4; k++) begin
            seed = lfsr(lfsr(seed));
            ptx  = seed[7:0];
            dat  = seed[15:8];
            bus(1'b1, 8'h20, 8'h20 | 8'(k));
            bus(1'b1, 8'h26, 8'(k >> 1));
            bus(1'b1, 8'h21, dat);
            bus(1'b1, 8'h20, 8'hA0 | 8'(k));
            while (irq !== 1'b1) @(posedge hclk);
            rchk(8'h23, 32'hFB);
            bus(1'b1, 8'h20, 8'h20 | 8'(k));
            repeat (4) @(posedge hclk);
            rchk(8'h23, 32'hF3);
            rchk(8'h21, {24'h0, ptx});
            chk(prx, dat);
            rchk(8'h24, 32'h07);
            @(posedge hclk);
            chk(irq, 1'b0);
        end
        // Abort in the shift state, before the first serial clock edge, on the slowest tested rate
        bus(1'b1, 8'h21, 8'h5A);
        bus(1'b1, 8'h20, 8'hA3);
        repeat (40) @(posedge hclk);
        rchk(8'h23, 32'hFF);
        bus(1'b1, 8'h20, 8'h63);
        // The abort pulse reaches the engine one edge after the data phase
        @(posedge hclk);
        rchk(8'h23, 32'hF3);
        bus(1'b1, 8'h23, 8'h16);
        bus(1'b1, 8'h23, 8'h15);
        rchk(8'h20, 32'h00);
        repeat (4) @(posedge hclk);
        rchk(8'h20, 32'h01);
        rchk(8'h23, 32'hF3);
        test_done();
    end
endmodule
`default_nettype wire
